// ==== include/serial_port_pkg.sv ====
// Constants, field layouts and carrier types shared by the dual serial port register block.
// Assumes a 100 MHz pclk domain and an APB master that decodes word addresses (index times four).
// Operation
// R01: Two independent asynchronous serial ports live side by side in one block.
// R02: Reading data offset with divisor access clear returns oldest received character.
// R03: Writing data offset with divisor access clear loads the transmit holding register.
// R04: Divisor bytes appear at offsets zero and one only while divisor access is set.
// R05: Low divisor byte gives bits 7:0, high byte gives bits 15:8 of one divisor.
// R06: Software writes the divisor high byte before the low byte.
// R07: The new divisor takes effect the moment the low byte is written.
// R08: Bit rate is clock divided by seven times the divisor.
// R09: Enable bit 3 lets modem status changes raise an interrupt, reset zero.
// R10: Enable bit 2 lets receiver line errors raise an interrupt.
// R11: Enable bit 1 lets an empty transmit holding register raise an interrupt.
// R12: Enable bit 0 lets received data raise an interrupt; bits 7:4 read zero.
// R13: Identification bits 3:1 give the highest pending source code; 7:4 read zero.
// R14: Identification bit 0 reads zero while pending, one otherwise, one after reset.
// R15: Offset two reads identification and writes go to FIFO control.
// R16: Code 011, line errors, top priority, cleared by reading line status.
// R17: Code 010 trigger level and 110 four-character timeout share second priority.
// R18: Code 001 holding empty, cleared by write or identification read; 000 modem, lowest.
// R19: Characters use a low start bit, data LSB first, one high stop bit.
// R20: Reading the receive buffer pops a character; empty clears data available.
package serial_port_pkg;

  localparam int unsigned N_PORTS_DEF   = 2;
  localparam int unsigned RX_DEPTH_DEF  = 16;
  localparam int unsigned DIV_W         = 16;
  localparam int unsigned PADDR_W       = 16;

  // Word indices; the byte address on the bus is four times the index.
  localparam logic [13:0] IDX_DATA_P0   = 14'h2500;
  localparam logic [13:0] IDX_IER_P0    = 14'h2501;
  localparam logic [13:0] IDX_IIR_P0    = 14'h2502;
  localparam logic [13:0] IDX_LCR_P0    = 14'h2503;
  localparam logic [13:0] IDX_LSR_P0    = 14'h2505;
  localparam logic [13:0] IDX_MSR_P0    = 14'h2506;
  localparam logic [13:0] PORT_STRIDE   = 14'h0010;

  localparam logic [7:0]  RBR_RESET     = 8'h00;
  localparam logic [7:0]  THR_RESET     = 8'h00;
  localparam logic [7:0]  DLL_RESET     = 8'h00;
  localparam logic [7:0]  DLM_RESET     = 8'h00;
  localparam logic [3:0]  IER_RESET     = 4'h0;
  localparam logic [7:0]  LCR_RESET     = 8'h00;
  localparam logic [1:0]  TRIG_RESET    = 2'h3;
  localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;

  localparam int unsigned LCR_DIVISOR_LATCH_ACCESS_BIT  = 7;
  localparam int unsigned IER_MSI_BIT   = 3;
  localparam int unsigned IER_RLS_BIT   = 2;
  localparam int unsigned IER_THRE_BIT  = 1;
  localparam int unsigned IER_RDA_BIT   = 0;
  localparam int unsigned FCR_RXRST_BIT = 1;
  localparam int unsigned FCR_TXRST_BIT = 2;

  localparam logic [2:0]  CODE_LINE     = 3'h3;
  localparam logic [2:0]  CODE_RXDATA   = 3'h2;
  localparam logic [2:0]  CODE_TIMEOUT  = 3'h6;
  localparam logic [2:0]  CODE_THRE     = 3'h1;
  localparam logic [2:0]  CODE_MODEM    = 3'h0;

  localparam logic [4:0]  TRIG_LVL0     = 5'h01;
  localparam logic [4:0]  TRIG_LVL1     = 5'h04;
  localparam logic [4:0]  TRIG_LVL2     = 5'h08;
  localparam logic [4:0]  TRIG_LVL3     = 5'h0E;

  localparam logic [2:0]  TICKS_PER_BIT = 3'd7;
  localparam logic [2:0]  RX_MID_TICK   = 3'd3;
  localparam logic [2:0]  LAST_DATA_BIT = 3'd7;
  localparam logic [5:0]  TIMEOUT_BITS  = 6'd40;

  typedef enum logic [1:0] {
    LINE_IDLE  = 2'b00,
    LINE_START = 2'b01,
    LINE_DATA  = 2'b11,
    LINE_STOP  = 2'b10
  } line_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       framing_err;
    logic       brk;
  } rx_event_t;

endpackage

// ==== src/serial_line_engine.sv ====
// Line side of one serial port: divisor prescaler, transmit and receive shifters.
// Assumes rxd is already synchronous to pclk and ce freezes every flip-flop.
`timescale 1ns/10ps
module serial_line_engine (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              ce,
  input  wire logic                              div_load,
  input  wire logic [serial_port_pkg::DIV_W-1:0] div_value,
  input  wire logic                              tx_start,
  input  wire logic [7:0]                        tx_data,
  input  wire logic                              rxd,
  output logic                                   txd,
  output logic                                   tx_busy,
  output logic                                   bit_tick,
  output serial_port_pkg::rx_event_t             rx_event
);
  import serial_port_pkg::*;

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] pre_q;
  logic             tick;
  logic [2:0]       bp_q;
  line_state_t      tx_st_q;
  logic [2:0]       tx_ph_q;
  logic [2:0]       tx_bit_q;
  logic [7:0]       tx_sh_q;
  line_state_t      rx_st_q;
  logic [2:0]       rx_ph_q;
  logic [2:0]       rx_bit_q;
  logic [7:0]       rx_sh_q;

  // A zero divisor stops the prescaler, so the line simply holds.
  assign tick     = ce && (div_q != '0) && (pre_q == div_q - 16'h0001); // [R08]
  assign bit_tick = tick && (bp_q == TICKS_PER_BIT - 3'd1);
  assign tx_busy  = (tx_st_q != LINE_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= DIV_RESET;
      pre_q <= '0;
      bp_q  <= '0;
    end else if (ce) begin
      if (div_load) begin
        div_q <= div_value; // [R07]
        pre_q <= '0;
        bp_q  <= '0;
      end else if (tick) begin
        pre_q <= '0;
        bp_q  <= (bp_q == TICKS_PER_BIT - 3'd1) ? 3'd0 : bp_q + 3'd1; // [R08]
      end else if (div_q != '0) begin
        pre_q <= pre_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q  <= LINE_IDLE;
      tx_ph_q  <= '0;
      tx_bit_q <= '0;
      tx_sh_q  <= '0;
      txd      <= 1'b1;
    end else if (ce) begin
      case (tx_st_q)
        LINE_IDLE: if (tx_start) begin
          tx_sh_q <= tx_data;
          tx_ph_q <= '0;
          tx_st_q <= LINE_START;
          txd     <= 1'b0; // [R19]
        end
        default: if (tick) begin
          if (tx_ph_q != TICKS_PER_BIT - 3'd1) begin
            tx_ph_q <= tx_ph_q + 3'd1;
          end else begin
            tx_ph_q <= '0;
            case (tx_st_q)
              LINE_START: begin
                tx_st_q  <= LINE_DATA;
                tx_bit_q <= '0;
                txd      <= tx_sh_q[0]; // [R19]
                tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
              end
              LINE_DATA: if (tx_bit_q == LAST_DATA_BIT) begin
                tx_st_q <= LINE_STOP;
                txd     <= 1'b1; // [R19]
              end else begin
                tx_bit_q <= tx_bit_q + 3'd1;
                txd      <= tx_sh_q[0];
                tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
              end
              default: tx_st_q <= LINE_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q  <= LINE_IDLE;
      rx_ph_q  <= '0;
      rx_bit_q <= '0;
      rx_sh_q  <= '0;
      rx_event <= '0;
    end else if (ce) begin
      rx_event.valid <= 1'b0;
      case (rx_st_q)
        LINE_IDLE: if (tick && !rxd) begin
          rx_st_q <= LINE_START;
          rx_ph_q <= '0;
        end
        LINE_START: if (tick) begin
          if (rx_ph_q != RX_MID_TICK) begin
            rx_ph_q <= rx_ph_q + 3'd1;
          end else if (rxd) begin
            rx_st_q <= LINE_IDLE; // A short low glitch is not a start bit.
          end else begin
            rx_st_q  <= LINE_DATA;
            rx_ph_q  <= '0;
            rx_bit_q <= '0;
          end
        end
        default: if (tick) begin
          if (rx_ph_q != TICKS_PER_BIT - 3'd1) begin
            rx_ph_q <= rx_ph_q + 3'd1;
          end else begin
            rx_ph_q <= '0;
            if (rx_st_q == LINE_DATA) begin
              rx_sh_q <= {rxd, rx_sh_q[7:1]}; // [R19]
              if (rx_bit_q == LAST_DATA_BIT) begin
                rx_st_q <= LINE_STOP;
              end else begin
                rx_bit_q <= rx_bit_q + 3'd1;
              end
            end else begin
              rx_st_q              <= LINE_IDLE;
              rx_event.valid       <= 1'b1;
              rx_event.data        <= rx_sh_q;
              rx_event.framing_err <= !rxd; // [R19]
              rx_event.brk         <= !rxd && (rx_sh_q == 8'h00);
            end
          end
        end
      endcase
    end
  end

endmodule

// ==== src/async_serial_port_regs.sv ====
// APB register front end for a set of identical asynchronous serial ports.
// Assumes an APB master in the pclk domain and line inputs already synchronous to pclk.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
module async_serial_port_regs #(
  parameter int unsigned N_PORTS  = serial_port_pkg::N_PORTS_DEF,
  parameter int unsigned RX_DEPTH = serial_port_pkg::RX_DEPTH_DEF
) (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                ce,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [serial_port_pkg::PADDR_W-1:0] paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic [N_PORTS-1:0]                  rxd,
  input  wire logic [N_PORTS-1:0]                  cts_n,
  output logic      [N_PORTS-1:0]                  txd,
  output logic      [N_PORTS-1:0]                  irq
);
  import serial_port_pkg::*;

  localparam int unsigned AW = $clog2(RX_DEPTH);
  localparam int unsigned CW = $clog2(RX_DEPTH + 1);

  logic        access;
  logic        done;
  logic        wr_done;
  logic        rd_done;
  logic [13:0] idx;
  logic [3:0]  off;
  logic [7:0]  rd_data [N_PORTS];
  logic [N_PORTS-1:0] hit;
  logic [N_PORTS-1:0] sel;
  logic [7:0]  rd_mux;
  logic        any_hit;

  // The answer comes one cycle into the access phase so prdata and pready leave flip-flops.
  assign access  = psel && penable && !pready;
  assign done    = psel && penable && pready;
  assign wr_done = done && pwrite;
  assign rd_done = done && !pwrite;
  assign idx     = paddr[PADDR_W-1:2];
  assign off     = idx[3:0];

  always_comb begin
    rd_mux  = 8'h00;
    any_hit = 1'b0;
    for (int p = 0; p < N_PORTS; p++) begin
      if (hit[p]) begin
        rd_mux  = rd_data[p];
        any_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= access;
      pslverr <= access && !any_hit;
      if (access) begin
        prdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  for (genvar gp = 0; gp < N_PORTS; gp++) begin : g_port // [R01]
    localparam logic [13:0] BASE = IDX_DATA_P0 + 14'(gp) * PORT_STRIDE;

    logic [7:0]    mem [RX_DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic [7:0]    dl_low_q;
    logic [7:0]    dl_high_q;
    logic [3:0]    ier_q;
    logic [7:0]    lcr_q;
    logic [1:0]    trig_q;
    logic [7:0]    thr_q;
    logic          thr_full_q;
    logic          thre_pend_q;
    logic          oe_q;
    logic          fe_q;
    logic          bi_q;
    logic          cts_q;
    logic          dcts_q;
    logic [5:0]    to_cnt_q;
    logic          divisor_latch_access;
    logic          div_load;
    logic          tx_busy;
    logic          bit_tick;
    logic          xfer;
    logic          push;
    logic          pop;
    logic          rx_flush;
    logic          thr_wr;
    logic          fcr_wr;
    logic          iir_rd;
    logic          lsr_rd;
    logic          msr_rd;
    logic          line_err;
    logic          rx_avail;
    logic          timed_out;
    logic          pending;
    logic [2:0]    code;
    logic [4:0]    trig_lvl;
    logic [7:0]    line_status;
    rx_event_t     rx_ev;

    assign sel[gp]  = (idx[13:4] == BASE[13:4]);
    assign divisor_latch_access     = lcr_q[LCR_DIVISOR_LATCH_ACCESS_BIT];
    assign thr_wr   = wr_done && sel[gp] && (off == IDX_DATA_P0[3:0]) && !divisor_latch_access; // [R03]
    assign div_load = wr_done && sel[gp] && (off == IDX_DATA_P0[3:0]) && divisor_latch_access; // [R07]
    assign fcr_wr   = wr_done && sel[gp] && (off == IDX_IIR_P0[3:0]); // [R15]
    assign pop      = rd_done && sel[gp] && (off == IDX_DATA_P0[3:0]) && !divisor_latch_access && (count_q != '0); // [R20]
    assign iir_rd   = rd_done && sel[gp] && (off == IDX_IIR_P0[3:0]);
    assign lsr_rd   = rd_done && sel[gp] && (off == IDX_LSR_P0[3:0]);
    assign msr_rd   = rd_done && sel[gp] && (off == IDX_MSR_P0[3:0]);
    assign rx_flush = fcr_wr && pwdata[FCR_RXRST_BIT];
    assign push     = rx_ev.valid && (count_q != CW'(RX_DEPTH)) && !rx_flush;
    assign xfer     = thr_full_q && !tx_busy;

    always_comb begin
      case (trig_q)
        2'h0:    trig_lvl = TRIG_LVL0;
        2'h1:    trig_lvl = TRIG_LVL1;
        2'h2:    trig_lvl = TRIG_LVL2;
        default: trig_lvl = TRIG_LVL3;
      endcase
    end

    assign line_err  = oe_q || fe_q || bi_q;
    assign rx_avail  = (count_q >= CW'(trig_lvl));
    assign timed_out = (count_q != '0) && (to_cnt_q >= TIMEOUT_BITS);

    // Fixed priority: line errors, then received data or timeout, then holding empty, then modem.
    always_comb begin
      pending = 1'b1;
      code    = CODE_MODEM;
      if (ier_q[IER_RLS_BIT] && line_err) begin
        code = CODE_LINE; // [R10] [R16]
      end else if (ier_q[IER_RDA_BIT] && rx_avail) begin
        code = CODE_RXDATA; // [R12] [R17]
      end else if (ier_q[IER_RDA_BIT] && timed_out) begin
        code = CODE_TIMEOUT; // [R17]
      end else if (ier_q[IER_THRE_BIT] && thre_pend_q) begin
        code = CODE_THRE; // [R11] [R18]
      end else if (ier_q[IER_MSI_BIT] && dcts_q) begin
        code = CODE_MODEM; // [R09] [R18]
      end else begin
        pending = 1'b0;
      end
    end

    assign line_status = {1'b0, !thr_full_q && !tx_busy, !thr_full_q, bi_q, fe_q, 1'b0, oe_q, count_q != '0};

    always_comb begin
      hit[gp]     = sel[gp];
      rd_data[gp] = 8'h00;
      case (off)
        IDX_DATA_P0[3:0]: rd_data[gp] = divisor_latch_access ? dl_low_q : mem[rd_ptr_q]; // [R02] [R04]
        IDX_IER_P0[3:0]:  rd_data[gp] = divisor_latch_access ? dl_high_q : {4'h0, ier_q}; // [R04] [R12]
        IDX_IIR_P0[3:0]:  rd_data[gp] = {4'h0, code, !pending}; // [R13] [R14] [R15]
        IDX_LCR_P0[3:0]:  rd_data[gp] = lcr_q;
        IDX_LSR_P0[3:0]:  rd_data[gp] = line_status;
        IDX_MSR_P0[3:0]:  rd_data[gp] = {3'h0, cts_q, 3'h0, dcts_q};
        default:          hit[gp] = 1'b0;
      endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dl_low_q  <= DLL_RESET;
        dl_high_q <= DLM_RESET;
        ier_q     <= IER_RESET;
        lcr_q     <= LCR_RESET;
        trig_q    <= TRIG_RESET;
      end else if (ce && wr_done && sel[gp]) begin
        case (off)
          IDX_DATA_P0[3:0]: if (divisor_latch_access) dl_low_q <= pwdata[7:0]; // [R04] [R05]
          IDX_IER_P0[3:0]: begin
            if (divisor_latch_access) begin
              dl_high_q <= pwdata[7:0]; // [R04] [R05] [R06]
            end else begin
              ier_q <= pwdata[3:0]; // [R09] [R10] [R11] [R12]
            end
          end
          IDX_IIR_P0[3:0]: trig_q <= pwdata[7:6];
          IDX_LCR_P0[3:0]: lcr_q <= pwdata[7:0];
          default: ;
        endcase
      end
    end

    // A write to the holding register while it is still full replaces the waiting byte.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        thr_q       <= THR_RESET;
        thr_full_q  <= 1'b0;
        thre_pend_q <= 1'b0;
      end else if (ce) begin
        if (thr_wr) begin
          thr_q <= pwdata[7:0]; // [R03]
        end
        thr_full_q <= thr_wr || (thr_full_q && !xfer && !(fcr_wr && pwdata[FCR_TXRST_BIT]));
        if (xfer) begin
          thre_pend_q <= 1'b1; // [R18]
        end else if (thr_wr || (iir_rd && pending && code == CODE_THRE)) begin
          thre_pend_q <= 1'b0; // [R18]
        end
      end
    end

    always_ff @(posedge pclk) begin
      if (ce && push) begin
        mem[wr_ptr_q] <= rx_ev.data;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        wr_ptr_q <= '0;
        rd_ptr_q <= '0;
        count_q  <= '0;
        to_cnt_q <= '0;
      end else if (ce) begin
        if (rx_flush) begin
          wr_ptr_q <= '0;
          rd_ptr_q <= '0;
          count_q  <= '0;
          to_cnt_q <= '0;
        end else begin
          if (push) wr_ptr_q <= AW'((32'(wr_ptr_q) + 1) % RX_DEPTH);
          if (pop) rd_ptr_q <= AW'((32'(rd_ptr_q) + 1) % RX_DEPTH); // [R20]
          count_q <= count_q + CW'(push) - CW'(pop); // [R20]
          if (push || pop || count_q == '0) begin
            to_cnt_q <= '0; // [R17]
          end else if (bit_tick && to_cnt_q < TIMEOUT_BITS) begin
            to_cnt_q <= to_cnt_q + 6'd1; // [R17]
          end
        end
      end
    end

    // Hardware set wins over a status read in the same cycle; an event one cycle earlier misses prdata and is cleared unread.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        oe_q   <= 1'b0;
        fe_q   <= 1'b0;
        bi_q   <= 1'b0;
        cts_q  <= 1'b0;
        dcts_q <= 1'b0;
        irq[gp] <= 1'b0;
      end else if (ce) begin
        oe_q   <= (rx_ev.valid && count_q == CW'(RX_DEPTH)) || (oe_q && !lsr_rd); // [R16]
        fe_q   <= (rx_ev.valid && rx_ev.framing_err) || (fe_q && !lsr_rd); // [R16]
        bi_q   <= (rx_ev.valid && rx_ev.brk) || (bi_q && !lsr_rd); // [R16]
        cts_q  <= !cts_n[gp];
        dcts_q <= (cts_q != !cts_n[gp]) || (dcts_q && !msr_rd); // [R18]
        irq[gp] <= pending;
      end
    end

    serial_line_engine u_engine (
      .pclk      (pclk),
      .presetn   (presetn),
      .ce        (ce),
      .div_load  (div_load),
      .div_value ({dl_high_q, pwdata[7:0]}),
      .tx_start  (xfer),
      .tx_data   (thr_q),
      .rxd       (rxd[gp]),
      .txd       (txd[gp]),
      .tx_busy   (tx_busy),
      .bit_tick  (bit_tick),
      .rx_event  (rx_ev)
    );
  end

endmodule

// ==== dv/async_serial_port_regs_assertions.sv ====
// Checker for the serial port register block, bound to its top-level ports.
// Assumes one pclk domain with presetn as asynchronous active-low reset.
`timescale 1ns/10ps
module async_serial_port_regs_assertions
  import serial_port_pkg::*;
#(
  parameter int unsigned N_PORTS = 2
) (
  input wire logic                                pclk,
  input wire logic                                presetn,
  input wire logic                                psel,
  input wire logic                                penable,
  input wire logic                                pwrite,
  input wire logic [serial_port_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0]                         prdata,
  input wire logic                                pready,
  input wire logic                                pslverr,
  input wire logic [N_PORTS-1:0]                  txd,
  input wire logic [N_PORTS-1:0]                  irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_wait;
    psel && penable && !pready;
  endsequence
  sequence iir_read;
    pready && psel && !pwrite && paddr[15:2] == IDX_IIR_P0;
  endsequence

  // A late pready would stall software, an early one would lose the setup data.
  chk_access_len: assert property (
    apb_setup ##1 apb_wait |=> pready ##1 !pready) else $error("access length wrong");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  chk_ready_cause: assert property (
    pready |-> $past(psel && penable)) else $error("pready without access");
  chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  chk_rdata_upper: assert property (
    pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  chk_iir_fields: assert property (
    iir_read |-> prdata[7:4] == 4'h0 && (!prdata[0] || prdata[3:1] == 3'h0)) else $error("iir fields");
  chk_tx_bit_len: assert property (
    $fell(txd[0]) |-> !txd[0] [*7]) else $error("short low bit");
  chk_reset_idle: assert property (
    $rose(presetn) |-> &txd && irq == '0) else $error("not idle after reset");
endmodule

bind async_serial_port_regs async_serial_port_regs_assertions #(.N_PORTS(N_PORTS)) chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd), .irq(irq)
);

// ==== dv/serial_peer.sv ====
// Behavioural remote serial peer: sends characters on rxd and captures txd.
// Assumes 8 data bits, one stop bit and a bit time given in pclk cycles.
`timescale 1ns/10ps
module serial_peer #(
  parameter int BIT = 7
) (
  input  wire logic pclk,
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] last;
  int         count = 0;

  initial rxd = 1'b1;

  // Sampling near mid-bit tolerates a few cycles of skew.
  initial begin
    forever begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge pclk);
        last[i] = txd;
      end
      repeat (BIT) @(posedge pclk);
      if (txd === 1'b1) count++;
    end
  end

  // A low stop bit goes out only when a test wants a framing error.
  task automatic send(input logic [7:0] v, input logic stop);
    rxd <= 1'b0;
    repeat (BIT) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      rxd <= v[i];
      repeat (BIT) @(posedge pclk);
    end
    rxd <= stop;
    repeat (BIT) @(posedge pclk);
    rxd <= 1'b1;
    repeat (BIT) @(posedge pclk);
  endtask
endmodule

// ==== dv/async_serial_port_regs_tb.sv ====
// Self-checking bench for the dual serial port register block over APB.
// Assumes the package, the bound checker and one serial peer on port zero.
`timescale 1ns/10ps
module async_serial_port_regs_tb;
  import serial_port_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rx0, er;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  cts_n, txd, irq;
  int          n_errors = 0;
  int          n_compared = 0;

  async_serial_port_regs async_serial_port_regs_inst (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd({1'b1, rx0}), .cts_n(cts_n), .txd(txd), .irq(irq)
  );
  // Seven clocks per bit matches a divisor of one.
  serial_peer #(.BIT(7)) serial_peer_inst (.pclk(pclk), .txd(txd[0]), .rxd(rx0));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [15:0] ad(input logic [13:0] p, input logic [13:0] o);
    return {IDX_DATA_P0 + p * PORT_STRIDE + o, 2'b00};
  endfunction

  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Values read just after an edge are the ones that edge sampled; only the watchdog ends a hung wait.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] e, input string m);
    apb(1'b0, a, 8'h00);
    cmp(rd, {24'h0, e}, m);
  endtask

  task automatic wait_irq(input string m);
    int n;
    n = 0;
    while (irq[0] !== 1'b1 && n < 2000) begin
      @(negedge pclk);
      n++;
    end
    cmp({31'h0, irq[0]}, 32'h1, m);
  endtask

  task automatic t_regs;
    rdc(ad(0, 2), 8'h01, "iir reset");
    rdc(ad(1, 2), 8'h01, "iir1 reset");
    wr(ad(0, 1), 8'hFF);
    rdc(ad(0, 1), 8'h0F, "ier bits");
    rdc(ad(1, 1), 8'h00, "ier1 apart");
    wr(ad(0, 1), 8'h00);
    wr(ad(0, 3), 8'h80);
    wr(ad(0, 1), 8'h12);
    wr(ad(0, 0), 8'h34);
    rdc(ad(0, 1), 8'h12, "div high");
    rdc(ad(0, 0), 8'h34, "div low");
    wr(ad(0, 1), 8'h00);
    wr(ad(0, 0), 8'h01);
    wr(ad(0, 3), 8'h00);
    rdc(ad(0, 1), 8'h00, "ier behind div");
    apb(1'b0, ad(0, 4), 8'h00);
    cmp({31'h0, er}, 32'h1, "unmapped");
    $display("registers done");
  endtask

  task automatic t_tx;
    int n;
    wr(ad(0, 1), 8'h02);
    wr(ad(0, 0), 8'hA5);
    wait_irq("thre irq");
    rdc(ad(0, 2), 8'h02, "iir thre");
    rdc(ad(0, 2), 8'h01, "thre cleared");
    n = 0;
    while (serial_peer_inst.count == 0 && n < 300) begin
      @(negedge pclk);
      n++;
    end
    cmp({24'h0, serial_peer_inst.last}, 32'hA5, "tx byte");
    cmp(serial_peer_inst.count, 32'h1, "tx stop");
    $display("transmit done");
  endtask

  task automatic t_rx;
    wr(ad(0, 2), 8'h00);
    wr(ad(0, 1), 8'h01);
    serial_peer_inst.send(8'h3C, 1'b1);
    wait_irq("rx irq");
    rdc(ad(0, 2), 8'h04, "iir data");
    rdc(ad(0, 0), 8'h3C, "rx byte");
    rdc(ad(0, 2), 8'h01, "rx drained");
    wr(ad(0, 2), 8'h40);
    serial_peer_inst.send(8'h5A, 1'b1);
    wait_irq("timeout irq");
    rdc(ad(0, 2), 8'h0C, "iir timeout");
    rdc(ad(0, 0), 8'h5A, "rx byte two");
    wr(ad(0, 1), 8'h04);
    serial_peer_inst.send(8'h55, 1'b0);
    wait_irq("line irq");
    rdc(ad(0, 2), 8'h06, "iir line");
    apb(1'b0, ad(0, 5), 8'h00);
    rdc(ad(0, 2), 8'h01, "line cleared");
    wr(ad(0, 2), 8'h02);
    wr(ad(0, 1), 8'h08);
    cts_n[0] <= 1'b0;
    wait_irq("modem irq");
    rdc(ad(0, 2), 8'h00, "iir modem");
    rdc(ad(0, 6), 8'h11, "modem status");
    rdc(ad(0, 2), 8'h01, "modem cleared");
    cmp({28'h0, txd, irq}, 32'hC, "lines idle");
    $display("receive done");
  endtask

  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 16'h0000;
    pwdata  = 32'h0;
    cts_n   = 2'h3;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    end_of_test();
  end

  initial begin
    #100000;
    n_errors++;
    $display("BAD %0t watchdog", $time);
    end_of_test();
  end
endmodule
